/* mrss_regs.svh */
// Register map, field positions, reset values and timing counts of the rate and sync block.
// Assumes 32-bit APB, one aligned word per register, byte addresses below.
`ifndef MRSS_REGS_SVH
`define MRSS_REGS_SVH

// Byte addresses
`define MRSS_ADDR_RATE_CFG 12'h000
`define MRSS_ADDR_FILTER_CFG 12'h004
`define MRSS_ADDR_SYNC_WORD 12'h008
`define MRSS_ADDR_SYNC_CTRL 12'h00c
`define MRSS_ADDR_OFFSET_EST 12'h010
`define MRSS_ADDR_OFFSET_TRIM 12'h014
`define MRSS_ADDR_STATUS 12'h018
`define MRSS_ADDR_TX_CTRL 12'h01c

// Rate configuration fields
`define MRSS_RATE_MANT_LSB 0
`define MRSS_RATE_EXP_LSB 8
`define MRSS_RATE_CFG_RST 12'h8f8

// Filter configuration fields
`define MRSS_FBW_MANT_LSB 0
`define MRSS_FBW_EXP_LSB 2
`define MRSS_FILTER_CFG_RST 4'h0

// Sync word reset value, upper byte then lower byte
`define MRSS_SYNC_WORD_RST 16'hd391

// Sync control fields
`define MRSS_SC_MODE_LSB 0
`define MRSS_SC_OOK_BIT 3
`define MRSS_SC_PQT_LSB 8
`define MRSS_SYNC_CTRL_RST 3'h2

// Transmit control fields
`define MRSS_TX_GO_BIT 0
`define MRSS_TX_PRE_LSB 8

// Phase accumulator width and the divide-by count of the filter table
`define MRSS_ACC_W 28
`define MRSS_FBW_BASE 8
`define MRSS_FBW_OFFSET 4

`endif

/* mrss_pkg.sv */
// Types shared by the rate and sync block.
// Assumes mrss_regs.svh supplies the numeric constants.
package mrss_pkg;

	// Sync detect settings, three-bit code
	typedef enum logic [2:0] {
		MRSS_SYNC_NONE = 3'h0,
		MRSS_SYNC_15 = 3'h1,
		MRSS_SYNC_16 = 3'h2,
		MRSS_SYNC_DBL = 3'h3,
		MRSS_SYNC_CS = 3'h4,
		MRSS_SYNC_15_CS = 3'h5,
		MRSS_SYNC_16_CS = 3'h6,
		MRSS_SYNC_DBL_CS = 3'h7
	} mrss_sync_mode_t;

	// Transmit framer phases
	typedef enum logic [1:0] {
		MRSS_TX_IDLE,
		MRSS_TX_PREAMBLE,
		MRSS_TX_SYNC
	} mrss_tx_state_t;

	// Receive sync search phases
	typedef enum logic [1:0] {
		MRSS_RX_SEARCH,
		MRSS_RX_SECOND,
		MRSS_RX_LOCKED
	} mrss_rx_state_t;

endpackage : mrss_pkg

/* mrss_rate_gen.sv */
// Phase accumulator symbol-rate generator.
// Assumes the core clock is the crystal clock and mantissa/exponent are steady settings.
`timescale 1ns/1ps
`default_nettype none
`include "mrss_regs.svh"

module mrss_rate_gen #(
	parameter int ACC_W = `MRSS_ACC_W
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Setting
	input wire logic [7:0] rate_mantissa,
	input wire logic [3:0] rate_exponent,
	// Tick, one per symbol, plus a half-symbol tick for sampling
	output logic sym_tick,
	output logic half_tick
);

	typedef struct packed {
		logic [ACC_W-1:0] acc;
		logic tick;
		logic half;
	} mrss_rg_state_t;

	mrss_rg_state_t s_q;
	mrss_rg_state_t s_d;
	logic [ACC_W:0] step;
	logic [ACC_W:0] sum;

	// Step is (256 + M) << E; overflow of 2^28 marks a symbol
	always_comb begin
		step = (ACC_W+1)'({1'b1, rate_mantissa}) << rate_exponent;
		sum = {1'b0, s_q.acc} + step;
		s_d = s_q;
		s_d.acc = sum[ACC_W-1:0];
		s_d.tick = sum[ACC_W];
		s_d.half = ~s_q.acc[ACC_W-1] & sum[ACC_W-1] & ~sum[ACC_W];
	end

	// Accumulator register
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sym_tick = s_q.tick;
	assign half_tick = s_q.half;

endmodule : mrss_rate_gen
`default_nettype wire

/* mrss_modem.sv */
// Rate generator, filter decode, offset trim, bit resync and sync-word search/insert.
// Assumes APB master on core_clk (crystal), demod supplies sliced bits, offset estimate,
// level, carrier flag and preamble quality from outside this block.
//
// Behaviour
// - Symbol rate is crystal times (256+mantissa) times 2^exponent over 2^28.
// - Generator covers 1.2 kbps to 500 kbps, step set by exponent.
// - Filter bandwidth is crystal over 8*(4+mantissa)*2^exponent.
// - Filter mantissa and exponent are two bits; 00/00 widest, 11/11 narrowest.
// - Filtering, offset compensation and level estimate are digital.
// - Frequency offset estimate readable in a read-only status register.
// - Writing the estimate into the trim retunes the synthesizer by it.
// - No offset compensation while on-off keying is selected.
// - Bit sync recovers symbol clock from expected rate, resyncing continuously.
// - Continuous sync search of 16 or 32 bits; sync inserted on transmit.
// - Only packets matching the configured sync word are accepted.
// - Correlate against 16-bit pattern, threshold 15/16 or 16/16.
// - Detection optionally qualified by preamble quality, carrier, or both.
// - With quality qualification, accept only if quality exceeds threshold.
// - Sync pattern comes from upper and lower byte registers; here one 16-bit sync word register holds both bytes.
// - Settings 3 and 7 send and match the 16-bit pattern twice.
// - Preamble is alternating one-zero bits ahead of the sync field.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "mrss_regs.svh"

module mrss_modem #(
	parameter int XTAL_HZ = 10000000,
	parameter int PRE_W = 4
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Receive side from demodulator
	input wire logic rx_soft_bit,
	input wire logic [7:0] demod_offset,
	input wire logic [7:0] demod_level,
	input wire logic carrier_sensed,
	input wire logic [4:0] preamble_quality_indicator,
	// Transmit side
	input wire logic payload_bit,
	output logic tx_bit,
	output logic tx_bit_valid,
	output logic payload_bit_take,
	// Decoded settings towards analog and filter
	output logic [1:0] filter_bw_mantissa,
	output logic [1:0] filter_bw_exponent,
	output logic [5:0] filter_decim,
	output logic [7:0] synth_offset_trim,
	output logic offset_comp_en,
	// Receive results
	output logic rx_bit,
	output logic rx_bit_valid,
	output logic sync_found
);

	typedef struct packed {
		logic [7:0] rate_mantissa;
		logic [3:0] rate_exponent;
		logic [1:0] fbw_mant;
		logic [1:0] fbw_exp;
		logic [15:0] sync_word;
		logic [2:0] sync_mode;
		logic ook_sel;
		logic [4:0] pq_thresh;
		logic [7:0] offset_trim;
		logic [7:0] offset_est;
		logic [7:0] level;
		logic [PRE_W-1:0] pre_bytes;
		logic tx_go;
		mrss_pkg::mrss_tx_state_t tx_st;
		logic [5:0] tx_cnt;
		logic tx_bit;
		logic tx_valid;
		logic take;
		logic [15:0] shreg;
		logic last_bit;
		logic [20:0] sym_cnt;
		logic [20:0] sym_per;
		logic [20:0] bit_tmr;
		logic sampled;
		logic rx_valid;
		mrss_pkg::mrss_rx_state_t rx_st;
		logic [4:0] bit_cnt;
		logic found;
		logic [31:0] rdata;
	} mrss_state_t;

	mrss_state_t s_q;
	mrss_state_t s_d;
	logic sym_tick;
	logic [15:0] cmp;
	logic [4:0] ones;
	logic corr_hit;
	logic qual_ok;
	logic dbl;
	logic wr;
	logic rd;
	logic [15:0] sh_next;

	// Accumulator generator shares the crystal clock
	mrss_rate_gen u_rate (
		.core_clk(core_clk),
		.reset(reset),
		.rate_mantissa(s_q.rate_mantissa),
		.rate_exponent(s_q.rate_exponent),
		.sym_tick(sym_tick),
		.half_tick()
	);

	// Mismatch count against the pattern, fresh bit included
	always_comb begin
		sh_next = {s_q.shreg[14:0], rx_soft_bit};
		cmp = sh_next ^ s_q.sync_word;
		ones = '0;
		for (int i = 0; i < 16; i++) begin
			ones = ones + 5'(cmp[i]);
		end
	end

	// Threshold and qualifiers
	always_comb begin
		unique case (s_q.sync_mode[1:0])
			2'h1: corr_hit = (ones <= 5'h01);
			2'h2, 2'h3: corr_hit = (ones == 5'h00);
			default: corr_hit = 1'b0;
		endcase
		qual_ok = (preamble_quality_indicator > s_q.pq_thresh);
		if (s_q.sync_mode[2] && !carrier_sensed) begin
			qual_ok = 1'b0;
		end
		if (s_q.pq_thresh == 5'h00) begin
			qual_ok = s_q.sync_mode[2] ? carrier_sensed : 1'b1;
		end
		dbl = (s_q.sync_mode[1:0] == 2'h3);
	end

	assign wr = psel & penable & pwrite;
	assign rd = psel & ~penable & ~pwrite;

	// Next-state logic for registers, transmit framer and receive search
	always_comb begin
		s_d = s_q;
		s_d.take = 1'b0;
		s_d.rx_valid = 1'b0;
		s_d.found = 1'b0;
		// Estimate sampled continuously; forced to zero under keying
		s_d.offset_est = s_q.ook_sel ? 8'h00 : demod_offset;
		s_d.level = demod_level;
		// Register writes land in the access phase
		if (wr) begin
			unique case (paddr)
				`MRSS_ADDR_RATE_CFG: begin
					s_d.rate_mantissa = pwdata[`MRSS_RATE_MANT_LSB +: 8];
					s_d.rate_exponent = pwdata[`MRSS_RATE_EXP_LSB +: 4];
				end
				`MRSS_ADDR_FILTER_CFG: begin
					s_d.fbw_mant = pwdata[`MRSS_FBW_MANT_LSB +: 2];
					s_d.fbw_exp = pwdata[`MRSS_FBW_EXP_LSB +: 2];
				end
				`MRSS_ADDR_SYNC_WORD: s_d.sync_word = pwdata[15:0];
				`MRSS_ADDR_SYNC_CTRL: begin
					s_d.sync_mode = pwdata[`MRSS_SC_MODE_LSB +: 3];
					s_d.ook_sel = pwdata[`MRSS_SC_OOK_BIT];
					s_d.pq_thresh = pwdata[`MRSS_SC_PQT_LSB +: 5];
				end
				`MRSS_ADDR_OFFSET_TRIM: s_d.offset_trim = pwdata[7:0];
				`MRSS_ADDR_TX_CTRL: begin
					s_d.tx_go = pwdata[`MRSS_TX_GO_BIT];
					s_d.pre_bytes = pwdata[`MRSS_TX_PRE_LSB +: PRE_W];
				end
				default: ;
			endcase
		end
		// Read data captured in setup, presented in access phase
		if (rd) begin
			unique case (paddr)
				`MRSS_ADDR_RATE_CFG: s_d.rdata = {20'h0, s_q.rate_exponent, s_q.rate_mantissa};
				`MRSS_ADDR_FILTER_CFG: s_d.rdata = {28'h0, s_q.fbw_exp, s_q.fbw_mant};
				`MRSS_ADDR_SYNC_WORD: s_d.rdata = {16'h0, s_q.sync_word};
				`MRSS_ADDR_SYNC_CTRL: s_d.rdata = {19'h0, s_q.pq_thresh, 4'h0, s_q.ook_sel,
					s_q.sync_mode};
				`MRSS_ADDR_OFFSET_EST: s_d.rdata = {24'h0, s_q.offset_est};
				`MRSS_ADDR_OFFSET_TRIM: s_d.rdata = {24'h0, s_q.offset_trim};
				`MRSS_ADDR_STATUS: s_d.rdata = {16'h0, s_q.level, 4'h0, s_q.tx_go,
					s_q.rx_st == mrss_pkg::MRSS_RX_LOCKED, 2'(s_q.tx_st)};
				`MRSS_ADDR_TX_CTRL: s_d.rdata = {(24-PRE_W)'(0), s_q.pre_bytes,
					7'h0, s_q.tx_go};
				default: s_d.rdata = 32'h0;
			endcase
		end
		// Transmit framer: preamble, sync (once or twice), then payload
		if (sym_tick) begin
			s_d.tx_valid = 1'b1;
			unique case (s_q.tx_st)
				mrss_pkg::MRSS_TX_IDLE: begin
					s_d.tx_valid = 1'b0;
					if (s_q.tx_go) begin
						s_d.tx_st = mrss_pkg::MRSS_TX_PREAMBLE;
						s_d.tx_cnt = '0;
					end
				end
				mrss_pkg::MRSS_TX_PREAMBLE: begin
					s_d.tx_bit = s_q.tx_cnt[0];
					s_d.tx_cnt = s_q.tx_cnt + 6'h01;
					if (s_q.tx_cnt[5:3] == 3'(s_q.pre_bytes) && s_q.tx_cnt[2:0] == 3'h7) begin
						s_d.tx_st = mrss_pkg::MRSS_TX_SYNC;
						s_d.tx_cnt = '0;
					end
				end
				mrss_pkg::MRSS_TX_SYNC: begin
					s_d.tx_bit = s_q.sync_word[4'hf - s_q.tx_cnt[3:0]];
					s_d.tx_cnt = s_q.tx_cnt + 6'h01;
					if (s_q.tx_cnt == (dbl ? 6'h1f : 6'h0f)) begin
						s_d.tx_st = mrss_pkg::MRSS_TX_IDLE;
						s_d.tx_go = 1'b0;
					end
				end
				default: s_d.tx_st = mrss_pkg::MRSS_TX_IDLE;
			endcase
		end
		// Payload follows the sync field from idle, with go cleared by hardware, until software sets go again
		if (sym_tick && s_q.tx_st == mrss_pkg::MRSS_TX_IDLE && s_q.tx_valid) begin
			s_d.tx_bit = payload_bit;
			s_d.tx_valid = 1'b1;
			s_d.take = 1'b1;
		end
		// Expected symbol length in cycles, measured between local ticks
		if (sym_tick) begin
			s_d.sym_per = s_q.sym_cnt + 21'h000001;
			s_d.sym_cnt = '0;
		end else begin
			s_d.sym_cnt = s_q.sym_cnt + 21'h000001;
		end
		// Bit timer restarts on every line edge, so drift never accumulates
		if (rx_soft_bit != s_q.last_bit) begin
			s_d.last_bit = rx_soft_bit;
			s_d.bit_tmr = '0;
		end else if (s_q.bit_tmr == s_q.sym_per - 21'h000001) begin
			s_d.bit_tmr = '0;
		end else begin
			s_d.bit_tmr = s_q.bit_tmr + 21'h000001;
		end
		// Sample half a symbol after the last boundary and run the search
		if (s_q.bit_tmr == (s_q.sym_per >> 1)) begin
			s_d.shreg = sh_next;
			s_d.sampled = rx_soft_bit;
			s_d.rx_valid = 1'b1;
			unique case (s_q.rx_st)
				// Search goes on while locked, so every new sync field is seen
				mrss_pkg::MRSS_RX_SEARCH, mrss_pkg::MRSS_RX_LOCKED: begin
					if (corr_hit && qual_ok) begin
						s_d.rx_st = dbl ? mrss_pkg::MRSS_RX_SECOND : mrss_pkg::MRSS_RX_LOCKED;
						s_d.bit_cnt = '0;
						s_d.found = ~dbl;
					end else if (s_q.sync_mode[1:0] == 2'h0) begin
						s_d.rx_st = mrss_pkg::MRSS_RX_SEARCH;
					end
				end
				mrss_pkg::MRSS_RX_SECOND: begin
					s_d.bit_cnt = s_q.bit_cnt + 5'h01;
					if (s_q.bit_cnt == 5'h0f) begin
						s_d.rx_st = corr_hit ? mrss_pkg::MRSS_RX_LOCKED
							: mrss_pkg::MRSS_RX_SEARCH;
						s_d.found = corr_hit;
					end
				end
				default: s_d.rx_st = mrss_pkg::MRSS_RX_SEARCH;
			endcase
		end
	end

	// One register for all block state except the rate accumulator, which u_rate holds
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			s_q <= '0;
			s_q.rate_mantissa <= 8'(`MRSS_RATE_CFG_RST);
			s_q.rate_exponent <= 4'(`MRSS_RATE_CFG_RST >> 8);
			s_q.sync_word <= `MRSS_SYNC_WORD_RST;
			s_q.sync_mode <= `MRSS_SYNC_CTRL_RST;
			s_q.tx_st <= mrss_pkg::MRSS_TX_IDLE;
			s_q.rx_st <= mrss_pkg::MRSS_RX_SEARCH;
		end else begin
			s_q <= s_d;
		end
	end

	// Filter decode: decimation is 8*(4+M)*2^E/8, bandwidth = xtal/(8*decim)
	assign filter_bw_mantissa = s_q.fbw_mant;
	assign filter_bw_exponent = s_q.fbw_exp;
	assign filter_decim = 6'((6'(`MRSS_FBW_OFFSET) + {4'h0, s_q.fbw_mant})
		<< s_q.fbw_exp);
	// Trim drives the synthesizer only when not keying
	assign synth_offset_trim = s_q.ook_sel ? 8'h00 : s_q.offset_trim;
	assign offset_comp_en = ~s_q.ook_sel;

	// APB answers in the access phase without wait states
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = s_q.rdata;
	assign tx_bit = s_q.tx_bit;
	assign tx_bit_valid = s_q.tx_valid;
	assign payload_bit_take = s_q.take;
	assign rx_bit = s_q.sampled;
	assign rx_bit_valid = s_q.rx_valid;
	assign sync_found = s_q.found;

endmodule : mrss_modem
`default_nettype wire

/* mrss_modem_monitor.sv */
// Checker for the rate and sync block, watching its top ports only.
// Assumes one core_clk domain and the register addresses of mrss_regs.svh.
`timescale 1ns/1ps
`default_nettype none
`include "mrss_regs.svh"

module mrss_monitor (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Settings
	input wire logic [1:0] filter_bw_mantissa,
	input wire logic [1:0] filter_bw_exponent,
	input wire logic [5:0] filter_decim,
	input wire logic [7:0] synth_offset_trim,
	input wire logic offset_comp_en,
	// Bit streams
	input wire logic tx_bit,
	input wire logic tx_bit_valid,
	input wire logic payload_bit_take,
	input wire logic rx_bit_valid,
	input wire logic sync_found
);
	// Single domain, so clock and reset are given once
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	apb_never_waits_a: assert property (pready && !pslverr)
		else $error("apb slave stalled or flagged error");
	decim_from_fields_a: assert property (
		filter_decim == ((6'h4 + {4'h0, filter_bw_mantissa}) << filter_bw_exponent))
		else $error("filter divide does not match its fields");
	filter_readback_a: assert property (
		psel && !penable && !pwrite && paddr == `MRSS_ADDR_FILTER_CFG
		|=> prdata == {28'h0, filter_bw_exponent, filter_bw_mantissa})
		else $error("filter read data differs from field ports");
	trim_write_a: assert property (
		psel && penable && pwrite && paddr == `MRSS_ADDR_OFFSET_TRIM && offset_comp_en
		|=> synth_offset_trim == $past(pwdata[7:0]))
		else $error("trim write did not reach synthesizer");
	keying_no_trim_a: assert property (!offset_comp_en |-> synth_offset_trim == 8'h00)
		else $error("trim applied while keying selected");
	sync_on_bit_a: assert property (sync_found |-> rx_bit_valid)
		else $error("sync found away from a bit");
	rx_bit_gap_a: assert property (rx_bit_valid |=> !rx_bit_valid [*8])
		else $error("recovered bits too close");
	tx_bit_hold_a: assert property (
		tx_bit_valid && $changed(tx_bit) |=> $stable(tx_bit) [*8])
		else $error("tx bit not held for a symbol");
	take_gap_a: assert property (payload_bit_take |=> !payload_bit_take [*8])
		else $error("payload bits taken too fast");

	// Main scenarios reached
	cover property (sync_found);
	cover property (payload_bit_take);
	cover property (!offset_comp_en);
endmodule : mrss_monitor

bind mrss_modem mrss_monitor u_mon (.core_clk, .reset, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .filter_bw_mantissa, .filter_bw_exponent,
	.filter_decim, .synth_offset_trim, .offset_comp_en, .tx_bit, .tx_bit_valid,
	.payload_bit_take, .rx_bit_valid, .sync_found);
`default_nettype wire

/* mrss_remote_tx.sv */
// Remote transmitter model: alternating preamble, frames sent on request.
// Assumes core_clk; its bit period is a little off the receiver's on purpose.
`timescale 1ns/1ps
`default_nettype none

module mrss_remote_tx #(
	parameter int BIT_CYC = 65
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Frame request
	input wire logic send,
	input wire logic [31:0] frame,
	input wire logic [5:0] nbits,
	// Air bit
	output logic line
);
	int cnt;
	int left;
	logic pend;
	logic [31:0] sh;

	// Own bit clock, so the receiver must keep resynchronising
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cnt <= 0;
			left <= 0;
			pend <= 1'b0;
			sh <= '0;
			line <= 1'b0;
		end else begin
			if (send)
				pend <= 1'b1;
			cnt <= (cnt == BIT_CYC - 1) ? 0 : cnt + 1;
			if (cnt == 0) begin
				if (left > 0) begin
					line <= sh[31];
					sh <= sh << 1;
					left <= left - 1;
				end else if (pend) begin
					line <= frame[31];
					sh <= frame << 1;
					left <= int'(nbits) - 1;
					pend <= 1'b0;
				end else begin
					line <= ~line;
				end
			end
		end
	end
endmodule : mrss_remote_tx
`default_nettype wire

/* tb_top.sv */
// Self-checking bench: APB tasks, register, framer and sync search tests.
// Assumes mrss_modem with its bound checker and the remote transmitter model.
`timescale 1ns/1ps
`default_nettype none
`include "mrss_regs.svh"

module tb_top;
	logic core_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r, frame = '0;
	logic pready, pslverr, payload_bit = 1'b1, tx_bit, tx_bit_valid, payload_bit_take;
	logic [7:0] demod_offset = 8'h3c, demod_level = 8'h5a, synth_offset_trim, pre;
	logic carrier_sensed = 1'b0, offset_comp_en, rx_bit, rx_bit_valid, sync_found, send = 1'b0;
	logic [4:0] preamble_quality_indicator = '0;
	logic [1:0] filter_bw_mantissa, filter_bw_exponent;
	logic [5:0] filter_decim, nbits = 6'h10;
	logic [15:0] sw;
	logic rx_soft_bit;
	int n_fail = 0, n_tests = 0, n_sync = 0, i, k, n0;
	// Receive cases: control, carrier, quality, frame, length, expected detection
	logic [31:0] c_ct [10] = '{32'h2, 32'h2, 32'h1, 32'h0, 32'h3, 32'h3, 32'h6, 32'h6,
		32'h502, 32'h502};
	logic [31:0] c_fr [10] = '{32'hb4e10000, 32'hb4e30000, 32'hb4e30000, 32'hb4e10000,
		32'hb4e1b4e1, 32'hb4e1b4e3, 32'hb4e10000, 32'hb4e10000, 32'hb4e10000, 32'hb4e10000};
	logic c_cs [10] = '{1, 1, 1, 1, 1, 1, 0, 1, 1, 1};
	logic [4:0] c_pq [10] = '{0, 0, 0, 0, 0, 0, 0, 0, 5, 6};
	logic c_ex [10] = '{1, 0, 1, 0, 1, 0, 0, 1, 0, 1};

	mrss_modem dut (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .rx_soft_bit, .demod_offset, .demod_level, .carrier_sensed,
		.preamble_quality_indicator, .payload_bit, .tx_bit, .tx_bit_valid, .payload_bit_take,
		.filter_bw_mantissa, .filter_bw_exponent, .filter_decim, .synth_offset_trim,
		.offset_comp_en, .rx_bit, .rx_bit_valid, .sync_found);
	mrss_remote_tx far (.core_clk, .reset, .send, .frame, .nbits, .line(rx_soft_bit));

	// Clock and detection count
	always #50 core_clk = ~core_clk;
	always @(posedge core_clk) if (sync_found === 1'b1) n_sync <= n_sync + 1;

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, s);
			n_fail++;
		end
	endtask : chk

	// Bounded wait ran out
	task automatic tmo(input int lim);
		if (i >= lim) begin
			n_fail++;
			complete_run();
		end
	endtask : tmo

	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge core_clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		r = prdata;
		tmo(20);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, '0);
		chk(nm, r, e);
	endtask : rdc

	initial begin
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		rdc("rate_rst", `MRSS_ADDR_RATE_CFG, 32'h8f8);
		rdc("filt_rst", `MRSS_ADDR_FILTER_CFG, 32'h0);
		rdc("sync_rst", `MRSS_ADDR_SYNC_WORD, 32'hd391);
		rdc("ctrl_rst", `MRSS_ADDR_SYNC_CTRL, 32'h2);
		apb(1'b1, 12'h020, 32'hffff);
		rdc("unmapped", 12'h020, 32'h0);
		apb(1'b1, `MRSS_ADDR_OFFSET_EST, 32'h11);
		rdc("estimate", `MRSS_ADDR_OFFSET_EST, 32'h3c);
		apb(1'b0, `MRSS_ADDR_STATUS, '0);
		chk("level", r[15:8], 32'h5a);
		apb(1'b1, `MRSS_ADDR_OFFSET_TRIM, 32'h3c);
		@(posedge core_clk);
		chk("trim", synth_offset_trim, 32'h3c);
		apb(1'b1, `MRSS_ADDR_SYNC_CTRL, 32'ha);
		@(posedge core_clk);
		chk("comp_en", offset_comp_en, 32'h0);
		chk("trim_ook", synth_offset_trim, 32'h0);
		rdc("est_ook", `MRSS_ADDR_OFFSET_EST, 32'h0);
		$display("test registers done");
		// Every filter code, from widest to narrowest
		for (k = 0; k < 16; k++) begin
			apb(1'b1, `MRSS_ADDR_FILTER_CFG, k);
			repeat (2) @(posedge core_clk);
			chk("decim", filter_decim, (4 + k[1:0]) << k[3:2]);
			chk("bw_fields", {filter_bw_exponent, filter_bw_mantissa}, k);
		end
		$display("test filter done");
		// Exponent 14, mantissa 0: one symbol each 64 cycles
		apb(1'b1, `MRSS_ADDR_SYNC_CTRL, 32'h2);
		apb(1'b1, `MRSS_ADDR_SYNC_WORD, 32'hb4e1);
		apb(1'b1, `MRSS_ADDR_RATE_CFG, 32'he00);
		rdc("rate", `MRSS_ADDR_RATE_CFG, 32'he00);
		apb(1'b1, `MRSS_ADDR_TX_CTRL, 32'h1);
		i = 0;
		while (tx_bit_valid !== 1'b1 && i < 300) begin
			@(posedge core_clk);
			i++;
		end
		tmo(300);
		// Sample each symbol in its middle
		repeat (32) @(posedge core_clk);
		for (k = 0; k < 24; k++) begin
			if (k < 8)
				pre = {pre[6:0], tx_bit};
			else
				sw = {sw[14:0], tx_bit};
			repeat (64) @(posedge core_clk);
		end
		chk("preamble", pre, 32'h55);
		chk("tx_sync", sw, 32'hb4e1);
		i = 0;
		while (payload_bit_take !== 1'b1 && i < 300) begin
			@(posedge core_clk);
			i++;
		end
		tmo(300);
		i = 0;
		do begin
			@(posedge core_clk);
			i++;
		end while (payload_bit_take !== 1'b1 && i < 300);
		chk("symbol_gap", i, 32'd64);
		apb(1'b0, `MRSS_ADDR_STATUS, '0);
		chk("go_clear", r[3], 32'h0);
		$display("test transmit done");
		// Sync search cases
		for (k = 0; k < 10; k++) begin
			apb(1'b1, `MRSS_ADDR_SYNC_CTRL, c_ct[k]);
			carrier_sensed <= c_cs[k];
			preamble_quality_indicator <= c_pq[k];
			frame <= c_fr[k];
			nbits <= c_fr[k][15:0] == 16'h0 ? 6'h10 : 6'h20;
			send <= 1'b1;
			n0 = n_sync;
			@(posedge core_clk);
			send <= 1'b0;
			i = 0;
			while (n_sync == n0 && i < 2600) begin
				@(posedge core_clk);
				i++;
			end
			chk("sync_found", n_sync != n0, c_ex[k]);
			if (c_ex[k])
				chk("rx_bit", rx_bit, 32'h1);
		end
		$display("test receive done");
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
